// ### ebd_pkg.sv
package ebd_pkg;

  // Bus widths.
  localparam int ADDR_W   = 24;
  localparam int DATA_W   = 16;
  localparam int MUXLO_W  = 8;
  localparam int MUXHI_W  = 5;
  localparam int SPACE_N  = 4;

  // Strobe scheme encodings on strobe_mode.
  localparam logic MODE_SPLIT  = 1'b0;
  localparam logic MODE_SINGLE = 1'b1;

  // Reset values of the link-side and core-side state.
  localparam logic             RST_PIN_HIGH = 1'b1;
  localparam logic             RST_PHASE    = 1'b0;
  localparam logic             RST_TOGGLE   = 1'b0;
  localparam logic [DATA_W-1:0] RST_DATA    = 16'h0000;
  localparam logic [ADDR_W-1:0] RST_ADDR    = 24'h000000;

  // Field positions of the DRAM row and column inside the byte address.
  localparam int COL_LSB = 1;
  localparam int ROW_LSB = 9;
  localparam int HI_ROW_LSB = 17;
  localparam int HI_COL_LSB = 12;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HOLD = 3'b001,
    ST_ADDR = 3'b010,
    ST_ROW  = 3'b011,
    ST_COL  = 3'b100,
    ST_XFER = 3'b101,
    ST_END  = 3'b110
  } ebd_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              write;
    logic              wide;
    logic              dram;
    logic              space_en;
    logic [1:0]        space_idx;
  } ebd_req_s;

endpackage : ebd_pkg

// ### ebd_sync.sv
module ebd_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous input and synchronised output
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RST;
      q      <= RST;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : ebd_sync

// ### ebd_external_bus.sv
module ebd_external_bus (
  // Core clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Link clock
  input  wire logic                         link_clk,
  // Software control
  input  wire logic                         strobe_mode,
  // Core request and answer
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire ebd_pkg::ebd_req_s            req,
  output logic                              resp_valid,
  output logic [ebd_pkg::DATA_W-1:0]        resp_rdata,
  // Address and data pins
  output logic [ebd_pkg::ADDR_W-1:0]        addr_out,
  output logic                              addr_oe,
  output logic [ebd_pkg::DATA_W-1:0]        data_out,
  output logic                              data_oe,
  input  wire logic [ebd_pkg::DATA_W-1:0]   data_in,
  // Bus strobes
  output logic                              strobe_oe,
  output logic                              read_strobe_n,
  output logic                              store_even_strobe_n,
  output logic                              store_odd_strobe_n,
  output logic                              store_strobe_n,
  output logic                              upper_byte_enable_n,
  output logic                              ale,
  output logic                              bus_clock_out,
  output logic [ebd_pkg::SPACE_N-1:0]       space_select_n,
  // Bus hold and wait
  input  wire logic                         bus_takeover_request_n,
  output logic                              bus_grant_ack_n,
  input  wire logic                         wait_request_n,
  // DRAM pins
  output logic                              dram_store_n,
  output logic                              row_strobe_n,
  output logic                              column_strobe_even_n,
  output logic                              column_strobe_odd_n,
  output logic [ebd_pkg::MUXLO_W-1:0]       dram_mux_addr_low,
  output logic [ebd_pkg::MUXHI_W-1:0]       dram_mux_addr_high
);

  // Row or column part of the DRAM address for both mux pin groups.
  function automatic logic [12:0] dram_mux(input logic [ebd_pkg::ADDR_W-1:0] a,
                                           input logic                      col);
    logic [12:0] r;
    if (col) begin
      r[7:0]  = a[ebd_pkg::COL_LSB +: 8];
      r[12:8] = a[ebd_pkg::HI_COL_LSB +: 5];
    end else begin
      r[7:0]  = a[ebd_pkg::ROW_LSB +: 8];
      r[12:8] = a[ebd_pkg::HI_ROW_LSB +: 5];
    end
    return r;
  endfunction : dram_mux

  // ---------------- Core domain ----------------
  ebd_pkg::ebd_req_s              pay_q;
  logic                           req_tog_q;
  logic                           ack_s;
  logic                           ack_q;
  logic                           done;
  logic                           resp_valid_q;
  logic [ebd_pkg::DATA_W-1:0]     resp_rdata_q;
  logic [ebd_pkg::DATA_W-1:0]     rdata_q;
  logic                           ack_tog_q;

  assign done       = ack_s ^ ack_q;
  assign req_ready  = (req_tog_q == ack_s);
  assign resp_valid = resp_valid_q;
  assign resp_rdata = resp_rdata_q;

  // The payload stays frozen until the link answers, so the link may read it directly.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_tog_q <= ebd_pkg::RST_TOGGLE;
      pay_q     <= '0;
    end else if (req_valid && req_ready) begin
      req_tog_q <= ~req_tog_q;
      pay_q     <= req;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q        <= ebd_pkg::RST_TOGGLE;
      resp_valid_q <= 1'b0;
      resp_rdata_q <= ebd_pkg::RST_DATA;
    end else begin
      ack_q        <= ack_s;
      resp_valid_q <= done;
      if (done) begin
        resp_rdata_q <= rdata_q;
      end
    end
  end

  ebd_sync #(.W(1), .RST(ebd_pkg::RST_TOGGLE)) u_ack_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (ack_tog_q),
    .q     (ack_s)
  );

  // ---------------- Link domain ----------------
  logic                           lrst_n;
  logic                           req_s;
  logic                           req_seen_q;
  logic                           mode_s;
  logic                           hold_s;
  logic                           wait_s;
  logic [ebd_pkg::DATA_W-1:0]     data_s;
  logic                           phase_q;
  logic                           phase_end;
  ebd_pkg::ebd_state_e            state_q;
  ebd_pkg::ebd_state_e            state_d;
  ebd_pkg::ebd_req_s              cur_q;
  logic                           in_xfer;
  logic                           in_cycle;
  logic                           odd_lane;
  logic                           even_lane;
  logic                           wr_cyc;
  logic [12:0]                    mux_d;
  logic                           pend;

  ebd_sync #(.W(1), .RST(1'b0)) u_rst_sync (
    .clk   (link_clk),
    .rst_n (1'b1),
    .d     (rst_n),
    .q     (lrst_n)
  );

  ebd_sync #(.W(4), .RST(4'hE)) u_ctl_sync (
    .clk   (link_clk),
    .rst_n (lrst_n),
    .d     ({bus_takeover_request_n, wait_request_n, strobe_mode, req_tog_q}),
    .q     ({hold_s, wait_s, mode_s, req_s})
  );

  ebd_sync #(.W(ebd_pkg::DATA_W), .RST(ebd_pkg::RST_DATA)) u_data_sync (
    .clk   (link_clk),
    .rst_n (lrst_n),
    .d     (data_in),
    .q     (data_s)
  );

  // One bus clock period is two link clocks; states move only at its end.
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      phase_q <= ebd_pkg::RST_PHASE;
    end else begin
      phase_q <= ~phase_q;
    end
  end

  assign phase_end     = phase_q;
  assign bus_clock_out = ~phase_q;
  assign pend          = (req_s != req_seen_q);

  always_comb begin
    state_d = state_q;
    if (phase_end) begin
      unique case (state_q)
        ebd_pkg::ST_IDLE: begin
          if (!hold_s) begin
            state_d = ebd_pkg::ST_HOLD;
          end else if (pend) begin
            state_d = ebd_pkg::ST_ADDR;
          end
        end
        ebd_pkg::ST_HOLD: begin
          if (hold_s) begin
            state_d = ebd_pkg::ST_IDLE;
          end
        end
        ebd_pkg::ST_ADDR: begin
          state_d = cur_q.dram ? ebd_pkg::ST_ROW : ebd_pkg::ST_XFER;
        end
        ebd_pkg::ST_ROW: begin
          state_d = ebd_pkg::ST_COL;
        end
        ebd_pkg::ST_COL, ebd_pkg::ST_XFER: begin
          if (wait_s) begin
            state_d = ebd_pkg::ST_END;
          end
        end
        ebd_pkg::ST_END: begin
          state_d = ebd_pkg::ST_IDLE;
        end
        default: begin
          state_d = ebd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      state_q <= ebd_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // A new request is taken only when the state machine leaves idle for it.
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      req_seen_q <= ebd_pkg::RST_TOGGLE;
      cur_q      <= '0;
    end else if (state_q == ebd_pkg::ST_IDLE && state_d == ebd_pkg::ST_ADDR) begin
      req_seen_q <= req_s;
      cur_q      <= pay_q;
    end
  end

  // Read data is caught at the completing bus clock edge; the answer toggles after.
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      rdata_q   <= ebd_pkg::RST_DATA;
      ack_tog_q <= ebd_pkg::RST_TOGGLE;
    end else begin
      if (in_xfer && state_d == ebd_pkg::ST_END && !cur_q.write) begin
        rdata_q <= data_s;
      end
      if (state_q == ebd_pkg::ST_END && state_d == ebd_pkg::ST_IDLE) begin
        ack_tog_q <= ~ack_tog_q;
      end
    end
  end

  // A pending payload is preloaded in idle so the address is valid while the latch pulse is high.
  assign mux_d = dram_mux(cur_q.addr, state_d == ebd_pkg::ST_COL);

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      addr_out           <= ebd_pkg::RST_ADDR;
      data_out           <= ebd_pkg::RST_DATA;
      dram_mux_addr_low  <= '0;
      dram_mux_addr_high <= '0;
    end else begin
      addr_out           <= (state_q == ebd_pkg::ST_IDLE && pend) ? pay_q.addr : cur_q.addr;
      data_out           <= (state_q == ebd_pkg::ST_IDLE && pend) ? pay_q.wdata : cur_q.wdata;
      dram_mux_addr_low  <= mux_d[7:0];
      dram_mux_addr_high <= mux_d[12:8];
    end
  end

  assign in_xfer   = (state_q == ebd_pkg::ST_XFER) || (state_q == ebd_pkg::ST_COL);
  assign in_cycle  = (state_q == ebd_pkg::ST_ADDR) || (state_q == ebd_pkg::ST_ROW) ||
                     in_xfer || (state_q == ebd_pkg::ST_END);
  assign odd_lane  = cur_q.addr[0] || cur_q.wide;
  assign even_lane = !cur_q.addr[0] || cur_q.wide;
  assign wr_cyc    = in_xfer && cur_q.write && !cur_q.dram;

  // The address, data and strobe drivers let go while the other master owns the bus.
  assign addr_oe   = (state_q != ebd_pkg::ST_HOLD);
  assign strobe_oe = (state_q != ebd_pkg::ST_HOLD);
  assign data_oe   = in_cycle && cur_q.write;

  assign bus_grant_ack_n = (state_q != ebd_pkg::ST_HOLD);
  assign ale             = (state_q == ebd_pkg::ST_ADDR) && !phase_q;
  assign read_strobe_n   = !(in_xfer && !cur_q.write);

  // The scheme is sampled live, so software should change it only with the bus idle.
  assign store_even_strobe_n = !(wr_cyc && even_lane && mode_s == ebd_pkg::MODE_SPLIT);
  assign store_odd_strobe_n  = !(wr_cyc && odd_lane && mode_s == ebd_pkg::MODE_SPLIT);
  assign store_strobe_n      = !(wr_cyc && mode_s == ebd_pkg::MODE_SINGLE);
  assign upper_byte_enable_n = !(in_cycle && odd_lane && mode_s == ebd_pkg::MODE_SINGLE);

  always_comb begin
    space_select_n = '1;
    if (in_cycle && cur_q.space_en && !cur_q.dram) begin
      space_select_n[cur_q.space_idx] = 1'b0;
    end
  end

  // RAS stays low through the column phase so the row stays open.
  assign row_strobe_n         = !(state_q == ebd_pkg::ST_ROW || state_q == ebd_pkg::ST_COL);
  assign column_strobe_even_n = !(state_q == ebd_pkg::ST_COL && even_lane);
  assign column_strobe_odd_n  = !(state_q == ebd_pkg::ST_COL && odd_lane);
  assign dram_store_n         = !(state_q == ebd_pkg::ST_COL && cur_q.write);

  // ---------------- Checks ----------------
  sequence s_row_col;
    (state_q == ebd_pkg::ST_ROW) [*2] ##1 (state_q == ebd_pkg::ST_COL);
  endsequence

  sequence s_addr_pulse;
    ale ##1 (!ale && state_q == ebd_pkg::ST_ADDR);
  endsequence

  chk_row_then_col: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    $rose(state_q == ebd_pkg::ST_ROW) |-> s_row_col)
    else $error("row phase did not last one bus clock before column phase");

  chk_ale_one_pulse: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    $rose(state_q == ebd_pkg::ST_ADDR) |-> s_addr_pulse)
    else $error("address latch pulse wrong");

  chk_hold_entry: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    (state_q == ebd_pkg::ST_IDLE && phase_q && !hold_s) |=> !bus_grant_ack_n [*2])
    else $error("hold request not acknowledged");

  chk_hold_release: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    !bus_grant_ack_n |-> (!addr_oe && !data_oe && !strobe_oe && read_strobe_n))
    else $error("bus still driven in hold");

  chk_grant_stays: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    (!bus_grant_ack_n && !hold_s) |=> !bus_grant_ack_n)
    else $error("grant dropped while request held");

  chk_wait_stretch: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    (in_xfer && phase_q && !wait_s) |=> (in_xfer [*2]))
    else $error("cycle completed while wait low");

  chk_wait_release: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    (in_xfer && phase_q && wait_s) |=> (state_q == ebd_pkg::ST_END))
    else $error("cycle not completed after ready sample");

  chk_split_lanes: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    (wr_cyc && mode_s == ebd_pkg::MODE_SPLIT && !cur_q.wide)
    |-> (store_even_strobe_n == cur_q.addr[0]) && (store_odd_strobe_n != cur_q.addr[0]))
    else $error("split write strobe on wrong lane");

  chk_single_bhe: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    (in_xfer && mode_s == ebd_pkg::MODE_SINGLE && cur_q.addr[0])
    |-> !upper_byte_enable_n && store_even_strobe_n && store_odd_strobe_n)
    else $error("upper byte enable missing in single scheme");

  chk_cas_inside_ras: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    (!column_strobe_even_n || !column_strobe_odd_n) |-> !row_strobe_n && $past(!row_strobe_n))
    else $error("column strobe without open row");

  chk_dram_store: assert property (
    @(posedge link_clk) disable iff (!lrst_n)
    (state_q == ebd_pkg::ST_COL && cur_q.write) |-> !dram_store_n && store_strobe_n)
    else $error("dram write strobe missing");

  chk_core_answer: assert property (
    @(posedge clk) disable iff (!rst_n)
    (req_valid && req_ready) |=> !req_ready)
    else $error("request taken while previous pending");

endmodule : ebd_external_bus

// ### ebd_bus_partner.sv
module ebd_bus_partner (
  // Link clock
  input  wire logic        link_clk,
  // Bench commands
  input  wire logic        hold_req,
  input  wire logic        wait_req,
  // Pins driven by the block
  input  wire logic [23:0] addr_out,
  input  wire logic [15:0] data_out,
  input  wire logic        read_strobe_n,
  input  wire logic        store_even_strobe_n,
  input  wire logic        store_odd_strobe_n,
  input  wire logic        store_strobe_n,
  input  wire logic        upper_byte_enable_n,
  input  wire logic        ale,
  input  wire logic [3:0]  space_select_n,
  input  wire logic        dram_store_n,
  input  wire logic        row_strobe_n,
  input  wire logic        column_strobe_even_n,
  input  wire logic        column_strobe_odd_n,
  input  wire logic [7:0]  dram_mux_addr_low,
  input  wire logic [4:0]  dram_mux_addr_high,
  // Pins driven by the far side
  output logic [15:0]      data_in,
  output logic             bus_takeover_request_n,
  output logic             wait_request_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem [16];
  logic [15:0] last_q;
  logic        act_q;
  logic        rd_s, ev_s, od_s, st_s, ub_s, dw_s, ras_s, ce_s, co_s;
  logic [3:0]  cs_s;
  logic [7:0]  row_lo, col_lo;
  logic [4:0]  row_hi, col_hi;
  logic [23:0] ale_addr;
  int          ale_n, rd_len;
  wire  [3:0]  ix = addr_out[4:1];

  assign bus_takeover_request_n = ~hold_req;
  assign wait_request_n = ~wait_req;
  // A released data bus shows the inverse of its last value, never a held copy.
  assign data_in = act_q ? mem[ix] : ~last_q;

  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    last_q = 16'h0000;
    act_q = 1'b0;
    ale_n = 0;
  end

  always @(posedge link_clk) begin
    if (ale) begin
      act_q <= 1'b1;
      {rd_s, ev_s, od_s, st_s, ub_s, dw_s, ras_s, ce_s, co_s} <= 9'h000;
      cs_s <= 4'hF;
      rd_len <= 0;
      ale_n <= ale_n + 1;
      ale_addr <= addr_out;
    end else begin
      rd_s <= rd_s | ~read_strobe_n;
      ev_s <= ev_s | ~store_even_strobe_n;
      od_s <= od_s | ~store_odd_strobe_n;
      st_s <= st_s | ~store_strobe_n;
      ub_s <= ub_s | ~upper_byte_enable_n;
      dw_s <= dw_s | ~dram_store_n;
      ras_s <= ras_s | ~row_strobe_n;
      ce_s <= ce_s | ~column_strobe_even_n;
      co_s <= co_s | ~column_strobe_odd_n;
      cs_s <= cs_s & space_select_n;
      rd_len <= rd_len + ((read_strobe_n === 1'b0) ? 1 : 0);
      if (!row_strobe_n && column_strobe_even_n && column_strobe_odd_n)
        {row_hi, row_lo} <= {dram_mux_addr_high, dram_mux_addr_low};
      if (!(column_strobe_even_n && column_strobe_odd_n))
        {col_hi, col_lo} <= {dram_mux_addr_high, dram_mux_addr_low};
      if ((rd_s | ev_s | od_s | st_s | dw_s) && read_strobe_n)
        act_q <= 1'b0;
    end
    if (act_q)
      last_q <= mem[ix];
    if (!store_even_strobe_n || (!store_strobe_n && !addr_out[0]) ||
        (!dram_store_n && !column_strobe_even_n))
      mem[ix][7:0] <= data_out[7:0];
    if (!store_odd_strobe_n || (!store_strobe_n && !upper_byte_enable_n) ||
        (!dram_store_n && !column_strobe_odd_n))
      mem[ix][15:8] <= data_out[15:8];
  end
endmodule : ebd_bus_partner

// ### ebd_external_bus_test.sv
module ebd_external_bus_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic [23:0]       addr_out;
  logic [15:0]       resp_rdata, data_out, data_in, rd;
  logic [7:0]        dram_mux_addr_low;
  logic [4:0]        dram_mux_addr_high;
  logic [3:0]        space_select_n;
  logic              clk, rst_n, link_clk, strobe_mode, req_valid, req_ready, resp_valid;
  logic              addr_oe, data_oe, strobe_oe, read_strobe_n, store_even_strobe_n;
  logic              store_odd_strobe_n, store_strobe_n, upper_byte_enable_n, ale;
  logic              bus_clock_out, bus_takeover_request_n, bus_grant_ack_n, wait_request_n;
  logic              dram_store_n, row_strobe_n, column_strobe_even_n, column_strobe_odd_n;
  logic              hold_req, wait_req;
  ebd_pkg::ebd_req_s req;
  int                errors, n_tests;

  ebd_external_bus dut (.clk, .rst_n, .link_clk, .strobe_mode, .req_valid, .req_ready, .req,
    .resp_valid, .resp_rdata, .addr_out, .addr_oe, .data_out, .data_oe, .data_in, .strobe_oe,
    .read_strobe_n, .store_even_strobe_n, .store_odd_strobe_n, .store_strobe_n,
    .upper_byte_enable_n, .ale, .bus_clock_out, .space_select_n, .bus_takeover_request_n,
    .bus_grant_ack_n, .wait_request_n, .dram_store_n, .row_strobe_n, .column_strobe_even_n,
    .column_strobe_odd_n, .dram_mux_addr_low, .dram_mux_addr_high);

  ebd_bus_partner pm (.link_clk, .hold_req, .wait_req, .addr_out, .data_out, .read_strobe_n,
    .store_even_strobe_n, .store_odd_strobe_n, .store_strobe_n, .upper_byte_enable_n, .ale,
    .space_select_n, .dram_store_n, .row_strobe_n, .column_strobe_even_n,
    .column_strobe_odd_n, .dram_mux_addr_low, .dram_mux_addr_high, .data_in,
    .bus_takeover_request_n, .wait_request_n);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // The odd start offset keeps the link clock out of phase with the core clock.
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever #15 link_clk = ~link_clk;
  end

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic send(input logic [23:0] a, input logic [15:0] w, input logic wr, wide, dram,
                      input logic [1:0] ix);
    int k;
    @(negedge clk);
    req = '{addr: a, wdata: w, write: wr, wide: wide, dram: dram, space_en: ~dram,
            space_idx: ix};
    req_valid = 1'b1;
    for (k = 0; k < 400 && req_ready !== 1'b1; k++) @(negedge clk);
    if (k == 400) begin
      errors++;
      end_sim();
    end
    @(negedge clk);
    req_valid = 1'b0;
  endtask : send

  task automatic await(output logic [15:0] d);
    int k;
    for (k = 0; k < 800 && resp_valid !== 1'b1; k++) @(negedge clk);
    if (k == 800) begin
      errors++;
      end_sim();
    end
    d = resp_rdata;
    @(negedge clk);
  endtask : await

  task automatic xfer(input logic [23:0] a, input logic [15:0] w, input logic wr, wide, dram,
                      input logic [1:0] ix);
    send(a, w, wr, wide, dram, ix);
    await(rd);
  endtask : xfer

  task automatic idle_check(output int seen);
    seen = 0;
    repeat (80) begin
      @(negedge clk);
      if (resp_valid === 1'b1) seen++;
    end
  endtask : idle_check

  task automatic wr_case(input logic m, input logic [23:0] a, input logic [15:0] w,
                         input logic wide, input logic [1:0] ix, input logic [4:0] exp);
    int a0;
    strobe_mode = m;
    repeat (12) @(negedge clk);
    a0 = pm.ale_n;
    xfer(a, w, 1'b1, wide, 1'b0, ix);
    chk("write strobes", exp,
        {pm.rd_s, pm.ev_s, pm.od_s, pm.st_s, pm.ub_s});
    chk("space select", 4'(~(4'h1 << ix)), pm.cs_s);
    chk("ale pulses", 24'h000001, 24'(pm.ale_n - a0));
    chk("latched address", a, pm.ale_addr);
    $display("write case %h done", a);
  endtask : wr_case

  task automatic rd_case(input logic [23:0] a, input logic [15:0] exp);
    xfer(a, 16'h0000, 1'b0, 1'b1, 1'b0, 2'h0);
    chk("read data", exp, rd);
    chk("read strobes", 5'b10000, {pm.rd_s, pm.ev_s, pm.od_s, pm.st_s, pm.dw_s});
    chk("read strobe length", 24'h000002, 24'(pm.rd_len));
    $display("read case %h done", a);
  endtask : rd_case

  task automatic t_dram();
    logic [23:0] a;
    a = 24'h2A4C36;
    xfer(a, 16'hC35A, 1'b1, 1'b1, 1'b1, 2'h0);
    chk("dram write strobes", 7'h78,
        {pm.dw_s, pm.ras_s, pm.ce_s, pm.co_s, pm.ev_s, pm.od_s, pm.st_s});
    chk("row mux", {a[21:17], a[16:9]}, {pm.row_hi, pm.row_lo});
    chk("column mux", {a[16:12], a[8:1]}, {pm.col_hi, pm.col_lo});
    chk("dram space select", 4'hF, pm.cs_s);
    xfer(a | 24'h000001, 16'h9696, 1'b1, 1'b0, 1'b1, 2'h0);
    chk("dram odd strobes", 3'b101, {pm.dw_s, pm.ce_s, pm.co_s});
    xfer(a, 16'h0000, 1'b0, 1'b1, 1'b1, 2'h0);
    chk("dram read data", 16'h965A, rd);
    chk("dram read strobes", 5'b10111,
        {pm.rd_s, pm.dw_s, pm.ras_s, pm.ce_s, pm.co_s});
    $display("dram test done");
  endtask : t_dram

  task automatic t_wait();
    int seen;
    wait_req = 1'b1;
    send(24'h000012, 16'h0000, 1'b0, 1'b1, 1'b0, 2'h0);
    idle_check(seen);
    chk("completion while waiting", 24'h0, 24'(seen));
    chk("read strobe while waiting", 1'b0, read_strobe_n);
    wait_req = 1'b0;
    await(rd);
    chk("read data after wait", 16'hA55A, rd);
    chk("stretched strobe", 2'b10, {pm.rd_len >= 4, pm.rd_len[0]});
    $display("wait test done");
  endtask : t_wait

  task automatic t_hold();
    int k, seen;
    hold_req = 1'b1;
    for (k = 0; k < 200 && bus_grant_ack_n !== 1'b0; k++) @(negedge clk);
    if (k == 200) begin
      errors++;
      end_sim();
    end
    chk("hold outputs", 4'h0,
        {bus_grant_ack_n, addr_oe, data_oe, strobe_oe});
    send(24'h00002E, 16'h5AA5, 1'b1, 1'b1, 1'b0, 2'h2);
    idle_check(seen);
    chk("completion in hold", 24'h0, 24'(seen));
    chk("grant held", 1'b0, bus_grant_ack_n);
    hold_req = 1'b0;
    await(rd);
    chk("grant released", 2'b11, {bus_grant_ack_n, addr_oe});
    rd_case(24'h00002E, 16'h5AA5);
    $display("hold test done");
  endtask : t_hold

  // The bus clock is sampled just after two link clock edges in a row.
  task automatic t_bclk();
    logic b;
    @(posedge link_clk);
    #1;
    b = bus_clock_out;
    @(posedge link_clk);
    #1;
    chk("bus clock toggle", !b, bus_clock_out);
    $display("bus clock test done");
  endtask : t_bclk

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    strobe_mode = 1'b0;
    hold_req = 1'b0;
    wait_req = 1'b0;
    errors = 0;
    n_tests = 0;
    // Reset spans enough link clock edges for the link side to clear as well.
    repeat (16) @(negedge clk);
    chk("reset pins", 7'h7E, {req_ready, bus_grant_ack_n, read_strobe_n, store_even_strobe_n,
        store_odd_strobe_n, store_strobe_n, resp_valid});
    rst_n = 1'b1;
    repeat (20) @(negedge clk);
    t_bclk();
    @(negedge clk);
    wr_case(1'b0, 24'h000010, 16'h1111, 1'b0, 2'h0, 5'b01000);
    wr_case(1'b0, 24'h000011, 16'h2222, 1'b0, 2'h1, 5'b00100);
    wr_case(1'b0, 24'h000012, 16'hA55A, 1'b1, 2'h2, 5'b01100);
    rd_case(24'h000010, 16'h2211);
    wr_case(1'b1, 24'h000020, 16'hBEEF, 1'b1, 2'h3, 5'b00011);
    wr_case(1'b1, 24'h000023, 16'h7777, 1'b0, 2'h0, 5'b00011);
    wr_case(1'b1, 24'h000024, 16'h3C3C, 1'b0, 2'h1, 5'b00010);
    rd_case(24'h000022, 16'h7700);
    rd_case(24'h000020, 16'hBEEF);
    rd_case(24'h000024, 16'h003C);
    t_dram();
    t_wait();
    t_hold();
    end_sim();
  end
endmodule : ebd_external_bus_test
